// ==== pkg/sms_pkg.sv ====
// Shared constants and types of the serial shifter
package sms_pkg;
  localparam int unsigned SMS_W = 16;
  localparam int unsigned SMS_FIFO_DEPTH = 4;
  localparam logic [5:0] SMS_EDGES_NARROW = 6'h10;
  localparam logic [5:0] SMS_EDGES_WIDE = 6'h20;
  localparam logic [5:0] SMS_EDGE_STEP = 6'h01;
  localparam logic [10:0] SMS_BAUD_ONE = 11'h001;
  localparam logic [10:0] SMS_BAUD_RESET = 11'h000;
  localparam logic [15:0] SMS_WORD_RESET = 16'h0000;
  localparam logic [3:0] SMS_PIN_RESET = 4'h8;
  localparam int unsigned SMS_PIN_SCK = 0;
  localparam int unsigned SMS_PIN_MOSI = 1;
  localparam int unsigned SMS_PIN_MISO = 2;
  localparam int unsigned SMS_PIN_SS = 3;
  typedef enum logic [1:0] {SMS_IDLE, SMS_SHIFT, SMS_FINISH} sms_state_t;
endpackage

// ==== pkg/sms_fifo_if.sv ====
// Valid/ready word channel between the shifter and its FIFO
`timescale 1ns/10ps
interface sms_fifo_if #(parameter int W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== design/sms_fifo.sv ====
// Small register FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sms_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Synchronised reset, active low
  sms_fifo_if.snk push, // Filling side
  sms_fifo_if.src pop // Draining side
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] PTR_ONE = (AW+1)'(1);
  localparam logic [AW:0] PTR_DEPTH = (AW+1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;

  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
    end else if (push.valid && !full) begin
      wr_ptr_r <= wr_ptr_r + PTR_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr_r <= '0;
    end else if (pop.ready && !empty) begin
      rd_ptr_r <= rd_ptr_r + PTR_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push.valid && !full) begin
      mem_r[wr_ptr_r[AW-1:0]] <= push.data;
    end
  end

  fifo_level_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_ptr_r - rd_ptr_r) <= PTR_DEPTH)
    else $error("FIFO holds more words than its depth");

  fifo_order_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      push.valid && push.ready && empty && !pop.ready |=> pop.valid && pop.data == $past(push.data))
    else $error("FIFO head differs from first word written");
endmodule

// ==== design/sms_spi_core.sv ====
// Serial peripheral shifter, master or slave, with transmit FIFO
`timescale 1ns/10ps
module sms_spi_core (
  input wire logic ref_clk_i, // Bus clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic master_select_i, // 1 master, 0 slave
  input wire logic clock_polarity_sel_i, // Idle clock level
  input wire logic clock_phase_sel_i, // 1 sample on even edges
  input wire logic [2:0] rate_sel_i, // Rate select field
  input wire logic [2:0] rate_presel_i, // Rate preselect field
  input wire logic single_wire_ctrl_i, // Single-wire data pin mode
  input wire logic bidir_out_enable_i, // Drive the shared data pin
  input wire logic fault_detect_enable_i, // Select pin in use
  input wire logic select_out_enable_i, // Select pin is an output
  input wire logic wide_xfer_i, // 1 sixteen bits, 0 eight bits
  input wire logic status_rd_i, // Status register read strobe
  input wire logic data_rd_i, // Data register read strobe
  input wire logic data_wr_i, // Data register write strobe
  input wire logic [sms_pkg::SMS_W-1:0] wr_data_i, // Data register write value
  input wire logic fault_clear_i, // Clears mode fault flag
  output logic [sms_pkg::SMS_W-1:0] serial_data_reg_o, // Receive buffer
  output logic tx_empty_flag_o, // Transmit data has room
  output logic xfer_done_flag_o, // Received word waiting
  output logic mode_fault_o, // Mode fault flag
  input wire logic sck_i, // Clock pin in
  output logic sck_o, // Clock pin out
  output logic sck_oe_o, // Clock pin drive
  input wire logic mosi_i, // Master-out pin in
  output logic mosi_o, // Master-out pin out
  output logic mosi_oe_o, // Master-out pin drive
  input wire logic miso_i, // Master-in pin in
  output logic miso_o, // Master-in pin out
  output logic miso_oe_o, // Master-in pin drive
  input wire logic ss_n_i, // Select pin in, active low
  output logic ss_n_o, // Select pin out, active low
  output logic ss_oe_o // Select pin drive
);
  import sms_pkg::*;

  logic rst_meta_r, rst_n_r, sck_prev_r, run_master_r, sck_lvl_r, in_bit_r;
  logic tx_armed_r, done_armed_r, xfer_done_flag_r, rx_pend_r, fault_r;
  logic [3:0] pin_meta_r, pin_sync_r;
  sms_state_t state_r;
  logic [15:0] sreg_r, rx_hold_r, rx_data_r;
  logic [5:0] edge_cnt_r;
  logic [10:0] baud_cnt_r, gap_r;
  logic [10:0] pre_plus, half_len;
  logic [5:0] edges_total, edge_num;
  logic [15:0] word_now, rx_word;
  logic din, sel_n_sync, tick, phase_hit, sample_edge, shift_edge, last_edge;
  logic start, abort, word_done, flag_clr, fault_set;

  sms_fifo_if #(.W(SMS_W)) push_if ();
  sms_fifo_if #(.W(SMS_W)) pop_if ();

  sms_fifo #(.W(SMS_W), .DEPTH(SMS_FIFO_DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= SMS_PIN_RESET;
      pin_sync_r <= SMS_PIN_RESET;
      sck_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= {ss_n_i, miso_i, mosi_i, sck_i};
      pin_sync_r <= pin_meta_r;
      sck_prev_r <= pin_sync_r[SMS_PIN_SCK];
    end
  end

  // ****************************************
  // Configuration decode and edge events
  // ****************************************
  assign pre_plus = {8'h00, rate_presel_i} + SMS_BAUD_ONE;
  assign half_len = pre_plus << rate_sel_i;
  assign edges_total = wide_xfer_i ? SMS_EDGES_WIDE : SMS_EDGES_NARROW;
  assign sel_n_sync = pin_sync_r[SMS_PIN_SS];
  // Shared data pin in single-wire mode, else the opposite data pin
  assign din = master_select_i ? (single_wire_ctrl_i ? pin_sync_r[SMS_PIN_MOSI] : pin_sync_r[SMS_PIN_MISO])
                               : (single_wire_ctrl_i ? pin_sync_r[SMS_PIN_MISO] : pin_sync_r[SMS_PIN_MOSI]);
  assign tick = (state_r == SMS_SHIFT) && (run_master_r ? (baud_cnt_r == half_len - SMS_BAUD_ONE)
                                                        : (pin_sync_r[SMS_PIN_SCK] ^ sck_prev_r));
  assign edge_num = edge_cnt_r + SMS_EDGE_STEP;
  assign phase_hit = edge_num[0] ^ clock_phase_sel_i;
  assign sample_edge = tick && phase_hit;
  assign shift_edge = tick && !phase_hit && !(clock_phase_sel_i && edge_num == SMS_EDGE_STEP);
  assign last_edge = (edge_num == edges_total);
  // Master waits for a queued word, slave for its select being low
  assign start = (state_r == SMS_IDLE) &&
                 (master_select_i ? (pop_if.valid && !fault_r) : !sel_n_sync);
  // Mode change mid-word drops the word rather than mixing roles
  assign abort = (state_r == SMS_SHIFT) && ((run_master_r != master_select_i) ||
                 (run_master_r ? fault_r : sel_n_sync));
  assign pop_if.ready = start;
  assign word_now = clock_phase_sel_i ? {sreg_r[14:0], in_bit_r} : sreg_r;
  assign rx_word = wide_xfer_i ? word_now : {8'h00, word_now[7:0]};
  assign word_done = (state_r == SMS_FINISH);

  // ****************************************
  // Shift engine
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= SMS_IDLE;
      run_master_r <= 1'b0;
      sreg_r <= SMS_WORD_RESET;
      edge_cnt_r <= '0;
      baud_cnt_r <= SMS_BAUD_RESET;
      sck_lvl_r <= 1'b0;
      in_bit_r <= 1'b0;
    end else begin
      unique case (state_r)
        SMS_IDLE: begin
          if (start) begin
            sreg_r <= pop_if.valid ? pop_if.data : SMS_WORD_RESET;
            run_master_r <= master_select_i;
            edge_cnt_r <= '0;
            baud_cnt_r <= SMS_BAUD_RESET;
            sck_lvl_r <= 1'b0;
            state_r <= SMS_SHIFT;
          end
        end
        SMS_SHIFT: begin
          if (abort) begin
            sck_lvl_r <= 1'b0;
            state_r <= SMS_IDLE;
          end else begin
            baud_cnt_r <= tick ? SMS_BAUD_RESET : baud_cnt_r + SMS_BAUD_ONE;
            if (tick) begin
              edge_cnt_r <= edge_num;
              if (run_master_r) begin
                sck_lvl_r <= !sck_lvl_r;
              end
              if (sample_edge) begin
                in_bit_r <= din;
              end
              if (shift_edge) begin
                sreg_r <= {sreg_r[14:0], in_bit_r};
              end
              if (last_edge) begin
                state_r <= SMS_FINISH;
              end
            end
          end
        end
        SMS_FINISH: begin
          sreg_r <= word_now;
          sck_lvl_r <= 1'b0;
          state_r <= SMS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gap_r <= SMS_BAUD_ONE;
    end else if (state_r != SMS_SHIFT || tick) begin
      gap_r <= SMS_BAUD_ONE;
    end else begin
      gap_r <= gap_r + SMS_BAUD_ONE;
    end
  end

  // ****************************************
  // Software flags and data buffers
  // ****************************************
  assign push_if.valid = data_wr_i && tx_armed_r;
  assign push_if.data = wr_data_i;
  assign tx_empty_flag_o = push_if.ready;
  assign flag_clr = data_rd_i && done_armed_r;
  assign fault_set = master_select_i && fault_detect_enable_i && !select_out_enable_i && !sel_n_sync;

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_armed_r <= 1'b0;
      done_armed_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      if (status_rd_i && tx_empty_flag_o) begin
        tx_armed_r <= 1'b1;
      end else if (data_wr_i) begin
        tx_armed_r <= 1'b0;
      end
      if (status_rd_i && xfer_done_flag_r) begin
        done_armed_r <= 1'b1;
      end else if (data_rd_i) begin
        done_armed_r <= 1'b0;
      end
      if (fault_set) begin
        fault_r <= 1'b1;
      end else if (fault_clear_i) begin
        fault_r <= 1'b0;
      end
    end
  end

  // Finished word waits in a holding stage until the done flag is clear
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_pend_r <= 1'b0;
      rx_hold_r <= SMS_WORD_RESET;
      rx_data_r <= SMS_WORD_RESET;
      xfer_done_flag_r <= 1'b0;
    end else begin
      if (word_done) begin
        rx_hold_r <= rx_word;
        rx_pend_r <= 1'b1;
      end else if (rx_pend_r && !xfer_done_flag_r) begin
        rx_pend_r <= 1'b0;
      end
      if (rx_pend_r && !xfer_done_flag_r) begin
        rx_data_r <= rx_hold_r;
        xfer_done_flag_r <= 1'b1;
      end else if (flag_clr) begin
        xfer_done_flag_r <= 1'b0;
      end
    end
  end

  assign serial_data_reg_o = rx_data_r;
  assign xfer_done_flag_o = xfer_done_flag_r;
  assign mode_fault_o = fault_r;

  // ****************************************
  // Pin drivers
  // ****************************************
  assign sck_o = clock_polarity_sel_i ^ sck_lvl_r;
  assign sck_oe_o = master_select_i;
  assign mosi_o = wide_xfer_i ? sreg_r[15] : sreg_r[7];
  assign miso_o = mosi_o;
  assign mosi_oe_o = master_select_i && (!single_wire_ctrl_i || bidir_out_enable_i);
  assign miso_oe_o = !master_select_i && (state_r != SMS_IDLE) &&
                     (!single_wire_ctrl_i || bidir_out_enable_i);
  assign ss_n_o = (state_r == SMS_IDLE);
  assign ss_oe_o = master_select_i && fault_detect_enable_i && select_out_enable_i;

  // ****************************************
  // Assertions
  // ****************************************
  ss_drive_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      master_select_i && fault_detect_enable_i && select_out_enable_i && run_master_r && state_r == SMS_SHIFT
      |-> ss_oe_o && !ss_n_o)
    else $error("Select not driven low during transfer");

  fault_flag_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      master_select_i && fault_detect_enable_i && !select_out_enable_i && !pin_sync_r[SMS_PIN_SS]
      |=> mode_fault_o)
    else $error("Low select input did not raise mode fault");

  idle_clock_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      master_select_i && state_r == SMS_IDLE |-> sck_o == clock_polarity_sel_i)
    else $error("Idle clock level wrong");

  slave_pins_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      !master_select_i |-> !sck_oe_o && !mosi_oe_o && !ss_oe_o)
    else $error("Slave drives a master pin");

  master_start_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      master_select_i && state_r == SMS_IDLE && pop_if.valid && !fault_r
      |=> state_r == SMS_SHIFT && sreg_r == $past(pop_if.data))
    else $error("Master did not load queued word");

  slave_wait_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      !master_select_i && state_r == SMS_IDLE && sel_n_sync |=> state_r == SMS_IDLE)
    else $error("Slave started without select");

  rx_move_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      word_done && !xfer_done_flag_r && !rx_pend_r
      |=> ##1 xfer_done_flag_o && serial_data_reg_o == $past(rx_word, 2))
    else $error("Received word not moved to buffer");

  tx_load_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      status_rd_i && tx_empty_flag_o && !data_wr_i ##1 data_wr_i |-> push_if.valid && push_if.ready)
    else $error("Armed data write not accepted");

  rate_gen_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      run_master_r && tick |-> gap_r == half_len)
    else $error("Serial clock half period wrong");

  pin_dir_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      master_select_i && single_wire_ctrl_i |-> mosi_oe_o == bidir_out_enable_i && !miso_oe_o)
    else $error("Single-wire pin direction wrong");

  width_a:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      word_done |-> edge_cnt_r == edges_total)
    else $error("Edge count differs from transfer width");
endmodule

// ==== tb/sms_peer.sv ====
// Behavioural peer shifter on the far side of the serial link
`timescale 1ns/10ps
module sms_peer (
  input wire logic sck_i, // Serial clock from the master
  input wire logic mosi_i, // Data from the master
  input wire logic ss_n_i, // Select, active low
  input wire logic phase_i, // High: sample on even edges
  input wire logic wide_i, // High: sixteen-bit words
  input wire logic [15:0] tx_word_i, // Word returned to the master
  output logic miso_o, // Data to the master
  output logic [15:0] rx_word_o, // Word received in the last frame
  output int edges_o // Clock edges seen in the last frame
);
  logic [15:0] shreg;

  initial miso_o = 1'b0;

  task automatic present();
    miso_o = wide_i ? shreg[15] : shreg[7];
    shreg = shreg << 1;
  endtask

  always @(negedge ss_n_i) begin
    edges_o = 0;
    rx_word_o = 16'h0000;
    shreg = tx_word_i;
    if (!phase_i) begin
      present();
    end
  end

  // Odd edges sample unless phase is set; the other edges shift the register on
  always @(sck_i) begin
    if (ss_n_i === 1'b0) begin
      edges_o = edges_o + 1;
      if (edges_o[0] ^ phase_i) begin
        rx_word_o = {rx_word_o[14:0], mosi_i};
      end else begin
        present();
      end
    end
  end

  // Released line does not keep its last level
  always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the serial shifter with a peer on its link
`timescale 1ns/10ps
module tb;
  import sms_pkg::*;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0;
  logic master_select_i = 1'b1, clock_polarity_sel_i = 1'b0, clock_phase_sel_i = 1'b0, wide_xfer_i = 1'b1;
  logic [2:0] rate_sel_i = 3'h1, rate_presel_i = 3'h1;
  logic single_wire_ctrl_i = 1'b0, bidir_out_enable_i = 1'b0, fault_detect_enable_i = 1'b1;
  logic select_out_enable_i = 1'b1, status_rd_i = 1'b0, data_rd_i = 1'b0, data_wr_i = 1'b0, fault_clear_i = 1'b0;
  logic [SMS_W-1:0] wr_data_i = 16'h0000, serial_data_reg_o;
  logic tx_empty_flag_o, xfer_done_flag_o, mode_fault_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o;
  logic miso_o, miso_oe_o, ss_n_o, ss_oe_o, b_sck = 1'b0, b_mosi = 1'b0, b_ss = 1'b1, peer_miso;
  logic [15:0] peer_tx = 16'h0000, peer_rx, got, w, mask;
  logic [15:0] peer_q[$];
  int peer_edges, hc, bad_count = 0, samples_checked = 0;
  realtime last_t = 0, half_t = 0;
  wire sck_pin = sck_oe_o ? sck_o : b_sck;
  wire mosi_pin = mosi_oe_o ? mosi_o : b_mosi;
  wire miso_pin = miso_oe_o ? miso_o : peer_miso;
  wire ss_pin = ss_oe_o ? ss_n_o : b_ss;

  always #20 ref_clk_i = ~ref_clk_i;

  sms_spi_core i_dut (.ref_clk_i, .reset_n_i, .master_select_i, .clock_polarity_sel_i, .clock_phase_sel_i,
    .rate_sel_i, .rate_presel_i, .single_wire_ctrl_i, .bidir_out_enable_i, .fault_detect_enable_i,
    .select_out_enable_i, .wide_xfer_i, .status_rd_i, .data_rd_i, .data_wr_i, .wr_data_i, .fault_clear_i,
    .serial_data_reg_o, .tx_empty_flag_o, .xfer_done_flag_o, .mode_fault_o, .sck_i(sck_pin), .sck_o,
    .sck_oe_o, .mosi_i(mosi_pin), .mosi_o, .mosi_oe_o, .miso_i(miso_pin), .miso_o, .miso_oe_o,
    .ss_n_i(ss_pin), .ss_n_o, .ss_oe_o);

  sms_peer i_peer (.sck_i(sck_pin), .mosi_i(mosi_pin), .ss_n_i(ss_pin), .phase_i(clock_phase_sel_i),
    .wide_i(wide_xfer_i), .tx_word_i(peer_tx), .miso_o(peer_miso), .rx_word_o(peer_rx), .edges_o(peer_edges));

  always @(posedge ss_pin) if (master_select_i) peer_q.push_back(peer_rx);
  always @(sck_pin) if (ss_pin === 1'b0) begin
    half_t = $realtime - last_t;
    last_t = $realtime;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
    samples_checked++;
    if (g !== e) begin
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
      bad_count++;
    end
  endtask

  task automatic put_word(input logic [15:0] v);
    @(negedge ref_clk_i);
    status_rd_i = 1'b1;
    @(negedge ref_clk_i);
    status_rd_i = 1'b0;
    data_wr_i = 1'b1;
    wr_data_i = v;
    @(negedge ref_clk_i);
    data_wr_i = 1'b0;
  endtask

  task automatic take_word(output logic [15:0] v);
    int n;
    n = 0;
    while (xfer_done_flag_o !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({15'h0000, xfer_done_flag_o}, 16'h0001, "done flag");
    status_rd_i = 1'b1;
    @(negedge ref_clk_i);
    status_rd_i = 1'b0;
    data_rd_i = 1'b1;
    v = serial_data_reg_o;
    @(negedge ref_clk_i);
    data_rd_i = 1'b0;
    @(negedge ref_clk_i);
    check({15'h0000, xfer_done_flag_o}, 16'h0000, "flag clear");
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #3ms;
    bad_count++;
    wrap_up();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (5) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    peer_q.delete();
    check(serial_data_reg_o, 16'h0000, "reset data");
    check({12'h000, tx_empty_flag_o, xfer_done_flag_o, mode_fault_o, ss_n_o}, 16'h0009, "reset flags");
    for (int k = 0; k < 3; k++) begin
      {single_wire_ctrl_i, bidir_out_enable_i} = 2'(k + 1);
      @(negedge ref_clk_i);
      check({15'h0000, mosi_oe_o}, {15'h0000, k != 1}, "data pin drive");
    end
    single_wire_ctrl_i = 1'b0;
    data_wr_i = 1'b1;
    wr_data_i = 16'h1234;
    @(negedge ref_clk_i);
    data_wr_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    check({15'h0000, ss_n_o}, 16'h0001, "unarmed write sent");
    for (int m = 0; m < 8; m++) begin
      {wide_xfer_i, clock_polarity_sel_i, clock_phase_sel_i} = 3'(m);
      rate_sel_i = m[2] ? 3'h2 : 3'h1;
      rate_presel_i = m[0] ? 3'h2 : 3'h1;
      hc = (m[0] ? 3 : 2) << (m[2] ? 2 : 1);
      mask = wide_xfer_i ? 16'hFFFF : 16'h00FF;
      w = 16'h9B17 + 16'(m * 1057);
      peer_tx = ~w;
      @(negedge ref_clk_i);
      check({15'h0000, sck_o}, {15'h0000, clock_polarity_sel_i}, "idle clock");
      check({15'h0000, sck_oe_o}, 16'h0001, "master clock drive");
      put_word(w);
      take_word(got);
      check(got, peer_tx & mask, "word from peer");
      check({15'h0000, ss_n_o}, 16'h0001, "idle select");
      check(peer_q.pop_front() & mask, w & mask, "word at peer");
      check(16'(peer_edges), wide_xfer_i ? 16'h0020 : 16'h0010, "clock edges");
      check(16'(half_t / 40), 16'(hc), "half period");
    end
    rate_sel_i = 3'h1;
    rate_presel_i = 3'h1;
    select_out_enable_i = 1'b0;
    @(negedge ref_clk_i);
    b_ss = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    b_ss = 1'b1;
    @(negedge ref_clk_i);
    check({15'h0000, mode_fault_o}, 16'h0001, "mode fault");
    peer_q.delete();
    for (int k = 0; k < 5; k++) begin
      put_word(16'h5000 + 16'(k));
    end
    check({15'h0000, tx_empty_flag_o}, 16'h0000, "buffer full");
    select_out_enable_i = 1'b1;
    peer_tx = 16'h0F0F;
    fault_clear_i = 1'b1;
    @(negedge ref_clk_i);
    fault_clear_i = 1'b0;
    @(negedge ref_clk_i);
    check({15'h0000, mode_fault_o}, 16'h0000, "fault cleared");
    for (int k = 0; k < 4; k++) begin
      take_word(got);
      check(got, 16'h0F0F, "drained reply");
    end
    repeat (300) @(negedge ref_clk_i);
    for (int k = 0; k < 4; k++) begin
      check(peer_q.pop_front(), 16'h5000 + 16'(k), "drained word");
    end
    check(16'(peer_q.size()), 16'h0000, "extra word");
    master_select_i = 1'b0;
    {wide_xfer_i, clock_polarity_sel_i, clock_phase_sel_i} = 3'h4;
    put_word(16'hB2E1);
    check({15'h0000, sck_oe_o}, 16'h0000, "slave clock drive");
    w = 16'h6D4C;
    b_ss = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      b_mosi = w[i];
      #160 b_sck = 1'b1;
      #80 got[i] = miso_oe_o ? miso_o : 1'bx;
      #80 b_sck = 1'b0;
    end
    #160 b_ss = 1'b1;
    check(got, 16'hB2E1, "slave reply");
    take_word(got);
    check(got, w, "slave receive");
    wrap_up();
  end
endmodule
